// File: hw/p6gp_defines.vh
/*
  constants for the port-six gpio / bus control pin block: register offsets,
  field positions and reset values. assumes byte-wide registers, one per
  aligned 32-bit wishbone word, except the pull-up option register at ff4eh.
*/
`ifndef P6GP_DEFINES_VH
`define P6GP_DEFINES_VH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define P6GP_ADDR_PULLUP_OPTION_LOW 16'hff4e
`define P6GP_ADDR_PULLUP_OPTION_LOW_IDX 16'hff4e
`define P6GP_ADDR_PORT_DATA 16'h0000
`define P6GP_ADDR_PORT_DIRECTION 16'h0004
`define P6GP_ADDR_MEMORY_EXPANSION 16'h0008
`define P6GP_ADDR_WAIT_CONTROL_ONE 16'h000c
`define P6GP_ADDR_WAIT_CONTROL_TWO 16'h0010
`define P6GP_ADDR_HOLD_MODE 16'h0014
`define P6GP_ADDR_REFRESH_MODE 16'h0018
`define P6GP_ADDR_PIN_STATUS 16'h001c

// ----------------------------------------------------------------------
// field positions and codes
// ----------------------------------------------------------------------
`define P6GP_PULLUP_SELECT_BIT 6
`define P6GP_HOLD_ENABLE_BIT 7
`define P6GP_REFRESH_ENABLE_BIT 7
`define P6GP_EXP_MODE_LSB 0
`define P6GP_EXP_MODE_MSB 3
`define P6GP_EXP_A16_A17 4'h8
`define P6GP_EXP_A16_A19 4'h9
`define P6GP_EXP_MODE_NONE_A 4'h0
`define P6GP_EXP_MODE_NONE_B 4'h3
`define P6GP_WAIT_EXTERNAL 2'h3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define P6GP_RST_PULLUP 8'h00
`define P6GP_RST_DIRECTION 8'hff
`define P6GP_RST_EXPANSION 8'h00
`define P6GP_RST_WAIT 8'h00
`define P6GP_RST_HOLD 8'h00
`define P6GP_RST_REFRESH 8'h00
`define P6GP_RST_LATCH 8'h00

`endif

// File: hw/p6gp_pin_cell.v
/*
  one port pin: chooses between the port latch and a control function and
  registers the pin's output, enable and pull-up. assumes clk_i domain only.
*/
`timescale 1ns/1ps
module p6gp_pin_cell (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire dir_in_i,
  input wire latch_i,
  input wire ctrl_sel_i,
  input wire ctrl_oe_i,
  input wire ctrl_val_i,
  input wire pullup_sel_i,
  output reg pin_o,
  output reg pin_oe_o,
  output reg pullup_o
);

  // --------------------------------------------------------------------
  // registered pin drive
  // --------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_o <= 1'b0;
      pin_oe_o <= 1'b0; // R18
      pullup_o <= 1'b0;
    end else if (ce_i) begin
      if (ctrl_sel_i) begin
        pin_o <= ctrl_val_i;
        pin_oe_o <= ctrl_oe_i; // R15
        pullup_o <= 1'b0;
      end else begin
        // latch is shown as soon as the pin turns to output
        pin_o <= latch_i; // R12
        pin_oe_o <= ~dir_in_i; // R11
        pullup_o <= pullup_sel_i & dir_in_i; // R16
      end
    end
  end

endmodule

// File: hw/p6gp_port.v
/*
  port-six gpio with external bus control pin functions, wishbone slave.
  assumes a classic wishbone master on clk_i and that the memory, wait,
  hold and refresh engines drive the alternate-function signals.
*/
// Overview of operation
// R1: non-control pins set in/out per direction bit
// R2: pins 0-3 carry upper address bits 16-19
// R3: mode 1000 gives two, 1001 four address pins
// R4: pin 4 is read strobe in expansion mode
// R5: pin 5 is write strobe in expansion mode
// R6: pin 6 is wait input when any region selects it
// R7: hold enable makes pin 6 hold request input
// R8: hold enable makes pin 7 hold acknowledge output
// R9: refresh enable makes pin 7 refresh request output
// R10: latch keeps value until next write
// R11: writes reach all latches; inputs stay undriven
// R12: input turned output drives latch at once
// R13: port read returns pin level for inputs
// R14: bit writes are full byte read-modify-write
// R15: control pins hidden from latch and read path
// R16: pull-up needs select bit and input direction
// R17: pull-up option register, reset 00h
// R18: reset makes all pins inputs, undriven
// R19: writes land next edge; pins registered
`timescale 1ns/1ps
`include "p6gp_defines.vh"
module p6gp_port #(
  parameter WIDTH = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [15:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [WIDTH-1:0] port_pin_i,
  output wire [WIDTH-1:0] port_pin_o,
  output wire [WIDTH-1:0] port_pin_oe_o,
  output wire [WIDTH-1:0] pullup_en_o,
  input wire [3:0] upper_address_out_i,
  input wire read_strobe_i,
  input wire write_strobe_i,
  input wire hold_ack_out_i,
  input wire refresh_request_out_i,
  output reg wait_in_o,
  output reg hold_request_in_o,
  output reg [7:0] pullup_option_low_o
);

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  reg [WIDTH-1:0] latch_q;
  reg [WIDTH-1:0] port_direction_reg_q;
  reg [7:0] memory_expansion_reg_q;
  reg [7:0] wait_control_reg_one_q;
  reg [7:0] wait_control_reg_two_q;
  reg [7:0] hold_mode_reg_q;
  reg [7:0] refresh_mode_reg_q;

  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];

  // --------------------------------------------------------------------
  // control function decode
  // --------------------------------------------------------------------
  wire [3:0] expansion_mode_field =
    memory_expansion_reg_q[`P6GP_EXP_MODE_MSB:`P6GP_EXP_MODE_LSB];
  wire addr_lo_sel = (expansion_mode_field == `P6GP_EXP_A16_A17) ||
                     (expansion_mode_field == `P6GP_EXP_A16_A19); // R3
  wire addr_hi_sel = (expansion_mode_field == `P6GP_EXP_A16_A19); // R3
  // any mode other than the two single-chip codes expands memory
  wire ext_mem = (expansion_mode_field != `P6GP_EXP_MODE_NONE_A) &&
                 (expansion_mode_field != `P6GP_EXP_MODE_NONE_B);

  // four 2-bit region fields per wait register, eight regions in all
  reg wait_sel;
  integer k;
  always @* begin
    wait_sel = 1'b0;
    for (k = 0; k < 4; k = k + 1) begin
      if (wait_control_reg_one_q[2*k +: 2] == `P6GP_WAIT_EXTERNAL)
        wait_sel = 1'b1;
      if (wait_control_reg_two_q[2*k +: 2] == `P6GP_WAIT_EXTERNAL)
        wait_sel = 1'b1;
    end
  end

  wire hold_en = hold_mode_reg_q[`P6GP_HOLD_ENABLE_BIT];
  wire refresh_en = refresh_mode_reg_q[`P6GP_REFRESH_ENABLE_BIT];

  reg [WIDTH-1:0] ctrl_sel;
  reg [WIDTH-1:0] ctrl_oe;
  reg [WIDTH-1:0] ctrl_val;
  always @* begin
    ctrl_sel = {WIDTH{1'b0}};
    ctrl_oe = {WIDTH{1'b0}};
    ctrl_val = {WIDTH{1'b0}};
    ctrl_sel[1:0] = {2{addr_lo_sel}}; // R2
    ctrl_sel[3:2] = {2{addr_hi_sel}}; // R2
    ctrl_oe[3:0] = 4'hf;
    ctrl_val[3:0] = upper_address_out_i; // R2
    ctrl_sel[4] = ext_mem; // R4
    ctrl_oe[4] = 1'b1;
    ctrl_val[4] = read_strobe_i; // R4
    ctrl_sel[5] = ext_mem; // R5
    ctrl_oe[5] = 1'b1;
    ctrl_val[5] = write_strobe_i; // R5
    ctrl_sel[6] = wait_sel | hold_en; // R6 R7
    ctrl_oe[6] = 1'b0;
    ctrl_sel[7] = hold_en | refresh_en; // R8 R9
    ctrl_oe[7] = 1'b1;
    // hold acknowledge takes the pin when both are enabled
    ctrl_val[7] = hold_en ? hold_ack_out_i : refresh_request_out_i; // R8 R9
  end

  // --------------------------------------------------------------------
  // pin cells
  // --------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
      p6gp_pin_cell u_cell (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .dir_in_i(port_direction_reg_q[g]), // R1
        .latch_i(latch_q[g]),
        .ctrl_sel_i(ctrl_sel[g]),
        .ctrl_oe_i(ctrl_oe[g]),
        .ctrl_val_i(ctrl_val[g]),
        .pullup_sel_i(pullup_option_low_o[`P6GP_PULLUP_SELECT_BIT]),
        .pin_o(port_pin_o[g]),
        .pin_oe_o(port_pin_oe_o[g]),
        .pullup_o(pullup_en_o[g])
      );
    end
  endgenerate

  // --------------------------------------------------------------------
  // port read value
  // --------------------------------------------------------------------
  // inputs show pin level, outputs their latch, control pins read zero
  wire [WIDTH-1:0] port_rd = ~ctrl_sel &
    ((port_direction_reg_q & port_pin_i) |
     (~port_direction_reg_q & latch_q)); // R13 R15

  // --------------------------------------------------------------------
  // register writes
  // --------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      latch_q <= `P6GP_RST_LATCH;
      port_direction_reg_q <= {WIDTH{1'b1}}; // R18
      memory_expansion_reg_q <= `P6GP_RST_EXPANSION;
      wait_control_reg_one_q <= `P6GP_RST_WAIT;
      wait_control_reg_two_q <= `P6GP_RST_WAIT;
      hold_mode_reg_q <= `P6GP_RST_HOLD;
      refresh_mode_reg_q <= `P6GP_RST_REFRESH;
      pullup_option_low_o <= `P6GP_RST_PULLUP; // R17
    end else if (ce_i && wb_wr) begin
      case (wb_adr_i)
        // whole byte always lands, including input and control bits;
        // software doing bit ops must read-modify-write the full byte
        `P6GP_ADDR_PORT_DATA: latch_q <= wb_dat_i[WIDTH-1:0]; // R10 R11 R14
        `P6GP_ADDR_PORT_DIRECTION:
          port_direction_reg_q <= wb_dat_i[WIDTH-1:0]; // R1 R12
        `P6GP_ADDR_MEMORY_EXPANSION: memory_expansion_reg_q <= wb_dat_i[7:0];
        `P6GP_ADDR_WAIT_CONTROL_ONE: wait_control_reg_one_q <= wb_dat_i[7:0];
        `P6GP_ADDR_WAIT_CONTROL_TWO: wait_control_reg_two_q <= wb_dat_i[7:0];
        `P6GP_ADDR_HOLD_MODE: hold_mode_reg_q <= wb_dat_i[7:0];
        `P6GP_ADDR_REFRESH_MODE: refresh_mode_reg_q <= wb_dat_i[7:0];
        `P6GP_ADDR_PULLUP_OPTION_LOW:
          pullup_option_low_o <= wb_dat_i[7:0]; // R17 R19
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // bus answer and alternate inputs
  // --------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      wait_in_o <= 1'b0;
      hold_request_in_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= wb_req; // R19
      wait_in_o <= wait_sel & port_pin_i[6]; // R6
      hold_request_in_o <= hold_en & port_pin_i[6]; // R7
      wb_dat_o <= 32'h00000000;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `P6GP_ADDR_PORT_DATA: wb_dat_o[WIDTH-1:0] <= port_rd; // R13
          `P6GP_ADDR_PORT_DIRECTION:
            wb_dat_o[WIDTH-1:0] <= port_direction_reg_q;
          `P6GP_ADDR_MEMORY_EXPANSION:
            wb_dat_o[7:0] <= memory_expansion_reg_q;
          `P6GP_ADDR_WAIT_CONTROL_ONE:
            wb_dat_o[7:0] <= wait_control_reg_one_q;
          `P6GP_ADDR_WAIT_CONTROL_TWO:
            wb_dat_o[7:0] <= wait_control_reg_two_q;
          `P6GP_ADDR_HOLD_MODE: wb_dat_o[7:0] <= hold_mode_reg_q;
          `P6GP_ADDR_REFRESH_MODE: wb_dat_o[7:0] <= refresh_mode_reg_q;
          `P6GP_ADDR_PULLUP_OPTION_LOW:
            wb_dat_o[7:0] <= pullup_option_low_o; // R17
          `P6GP_ADDR_PIN_STATUS: wb_dat_o[WIDTH-1:0] <= port_pin_i;
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// File: testbench/p6gp_port_assertions.sv
/* checker of the port-six block: bus handshake, pull-up register, pin
   timing. assumes ce_i stays high. */
`timescale 1ns/1ps
module p6gp_port_assertions #(
  parameter WIDTH = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [15:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [WIDTH-1:0] port_pin_i,
  input wire [WIDTH-1:0] port_pin_oe_o,
  input wire [WIDTH-1:0] pullup_en_o,
  input wire wait_in_o,
  input wire hold_request_in_o,
  input wire [7:0] pullup_option_low_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_puwr;
    s_req ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == 16'hff4e);
  endsequence
  a_ack_next: assert property (s_req |=> wb_ack_o)
    else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data outside ack");
  a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper data set");
  a_pu_write: assert property (s_puwr |=>
    pullup_option_low_o == $past(wb_dat_i[7:0]))
    else $error("pull-up write lost");
  a_pu_gate: assert property ((|pullup_en_o) |->
    $past(pullup_option_low_o[6]))
    else $error("pull-up without select");
  a_reset_in: assert property ($fell(rst_i) |-> port_pin_oe_o == 0)
    else $error("pin driven after reset");
  a_wait_pin: assert property (wait_in_o |-> $past(port_pin_i[6]))
    else $error("wait not from pin");
  a_hold_pin: assert property (hold_request_in_o |->
    $past(port_pin_i[6]))
    else $error("hold not from pin");
endmodule
bind p6gp_port p6gp_port_assertions #(.WIDTH(WIDTH)) i_chk (.*);

// File: testbench/p6gp_far_model.sv
/* far side of the pins: memory and bus-hold master. assumes the bench
   says which released pins it drives. */
`timescale 1ns/1ps
module p6gp_far_model (
  input wire clk_i,
  input wire [7:0] pin_o_i,
  input wire [7:0] oe_i,
  input wire [7:0] pull_i,
  input wire [7:0] ext_i,
  input wire [7:0] ext_en_i,
  output wire [7:0] lvl_o
);
  // start from a known level, lost at the first edge while oe_i is unknown, so a pin floating from the start reads unknown
  reg [7:0] flt_q = 8'h00;
  // a floating line keeps toggling so a stale level cannot pass
  always @(posedge clk_i) begin
    flt_q <= ~lvl_o;
  end
  assign lvl_o = (oe_i & pin_o_i) |
    (~oe_i & ext_en_i & ext_i) |
    (~oe_i & ~ext_en_i & (pull_i | flt_q));
endmodule

// File: testbench/tb_top.sv
/* bench of the port-six block: register rows, control pins. assumes
   the far model resolves every pin level. */
`timescale 1ns/1ps
module tb_top;
  reg clk_i = 0, rst_i = 1, cyc = 0, we = 0;
  reg rs = 0, ws = 0, ha = 0, rr = 0;
  reg [3:0] ua = 4'h0;
  reg [15:0] adr = 16'h0;
  reg [31:0] dat = 32'h0, q;
  reg [7:0] ext = 8'h0, ext_en = 8'h0;
  reg [39:0] rows [0:3];
  integer errors = 0, checks = 0, cyc_n = 0, i;
  wire [31:0] dat_o;
  wire ack, wt, hq;
  wire [7:0] pin, pin_o, oe, pull, puo;
  initial forever #12.5 clk_i = ~clk_i;
  p6gp_port i_p6gp_port (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .port_pin_i(pin), .port_pin_o(pin_o), .port_pin_oe_o(oe),
    .pullup_en_o(pull), .upper_address_out_i(ua), .read_strobe_i(rs),
    .write_strobe_i(ws), .hold_ack_out_i(ha), .refresh_request_out_i(rr),
    .wait_in_o(wt), .hold_request_in_o(hq), .pullup_option_low_o(puo));
  p6gp_far_model i_p6gp_far_model (.clk_i(clk_i), .pin_o_i(pin_o),
    .oe_i(oe), .pull_i(pull), .ext_i(ext), .ext_en_i(ext_en), .lvl_o(pin));
  task chk(input [7:0] s, input [7:0] e);
    begin
      checks = checks + 1;
      if (s !== e) begin
        errors = errors + 1;
        $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task wb(input w, input [15:0] a, input [7:0] d);
    begin
      cyc <= 1;
      we <= w;
      adr <= a;
      dat <= {24'h0, d};
      @(posedge clk_i);
      while (ack !== 1'b1) @(posedge clk_i);
      q = dat_o;
      cyc <= 0;
      we <= 0;
      @(posedge clk_i);
    end
  endtask
  task rd(input [15:0] a, input [7:0] e);
    begin
      wb(0, a, 8'h00);
      chk(q[7:0], e);
    end
  endtask
  task port(input [39:0] r);
    begin
      ext <= r[23:16];
      ext_en <= 8'hff;
      wb(1, 16'hff4e, r[15:8]);
      wb(1, 16'h0000, r[31:24]);
      wb(1, 16'h0004, r[39:32]);
      chk(oe, ~r[39:32]);
      chk(pin_o & oe, r[31:24] & oe);
      chk(pull, r[14] ? r[39:32] : 8'h00);
      rd(16'h0000, r[7:0]);
    end
  endtask
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 4000) begin
      errors = errors + 1;
      finish_test;
    end
  end
  initial begin
    rows[0] = 40'h00a5_0000_a5;
    rows[1] = 40'hff3c_9640_96;
    rows[2] = 40'h0f5a_c340_53;
    rows[3] = 40'hf069_1200_19;
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    chk(oe, 8'h00);
    rd(16'hff4e, 8'h00);
    rd(16'h0004, 8'hff);
    rd(16'h0040, 8'h00);
    wb(1, 16'hff4e, 8'h7f);
    chk(puo, 8'h7f);
    $display("reset test done");
    for (i = 0; i < 4; i = i + 1) begin
      port(rows[i]);
      $display("row %0d done", i);
    end
    // latch written while input must appear once the pin turns output
    port(40'hff81_0000_00);
    wb(1, 16'h0004, 8'h00);
    chk(pin_o & oe, 8'h81);
    port(40'hff00_ff40_ff);
    ua <= 4'hb;
    rs <= 1;
    wb(1, 16'h0008, 8'h08);
    chk(oe, 8'h33);
    chk(pin_o & 8'h33, 8'h13);
    rd(16'h0000, 8'hcc);
    ws <= 1;
    wb(1, 16'h0008, 8'h09);
    chk(oe, 8'h3f);
    chk(pin_o & 8'h3f, 8'h3b);
    chk(pin_o & oe & 8'h20, 8'h20);
    rd(16'h0000, 8'hc0);
    // raw pin view still shows the control pins that the port hides
    rd(16'h001c, 8'hfb);
    wb(1, 16'h0008, 8'h03);
    chk(oe, 8'h00);
    $display("expansion test done");
    ha <= 1;
    wb(1, 16'h0014, 8'h80);
    chk(pin_o & oe & 8'h80, 8'h80);
    chk({7'h0, hq}, 8'h01);
    ext <= 8'hbf;
    repeat (2) @(posedge clk_i);
    chk({7'h0, hq}, 8'h00);
    wb(1, 16'h0014, 8'h00);
    ha <= 0;
    rr <= 1;
    wb(1, 16'h0018, 8'h80);
    chk(pin_o & oe & 8'h80, 8'h80);
    wb(1, 16'h000c, 8'h03);
    ext <= 8'hff;
    repeat (2) @(posedge clk_i);
    chk({7'h0, wt}, 8'h01);
    ext <= 8'hbf;
    repeat (2) @(posedge clk_i);
    chk({7'h0, wt}, 8'h00);
    $display("control test done");
    // reset in mid-run must release the refresh pin and clear the modes
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    chk(oe, 8'h00);
    rd(16'h0004, 8'hff);
    rd(16'h0018, 8'h00);
    rd(16'hff4e, 8'h00);
    $display("mid-run reset test done");
    finish_test;
  end
endmodule
